// ==== rtl/nvc_consts.svh ====
/*
 * Constants of the nested vector controller: exception numbers, vector
 * offsets, key limits and timing counts.
 * Assumes it is included by the package and the design modules only.
 */
`ifndef NVC_CONSTS_SVH
`define NVC_CONSTS_SVH

// ==========================================================================
// Exception numbering
// ==========================================================================
`define NVC_EXC_NUM 48
`define NVC_IRQ_NUM 32
`define NVC_IRQ_BASE 6'd16
`define NVC_EXC_NMI 6'd2
`define NVC_EXC_HARD 6'd3
`define NVC_EXC_MEM 6'd4
`define NVC_EXC_BUS 6'd5
`define NVC_EXC_USAGE 6'd6
`define NVC_EXC_SVC 6'd11
`define NVC_EXC_DEBUG 6'd12
`define NVC_EXC_DEFER 6'd14
`define NVC_EXC_TICK 6'd15
// Numbers 0, 1, 7 to 10 and 13 are never pended.
`define NVC_NEVER_PEND 48'h0000_0000_2783

// ==========================================================================
// Vector table
// ==========================================================================
`define NVC_OFF_W 10
`define NVC_OFF_STACK 10'h000
`define NVC_OFF_RESET 10'h004

// ==========================================================================
// Priority
// ==========================================================================
`define NVC_PRIO_MIN_BITS 4'd3
`define NVC_PRIO_MAX_BITS 4'd8
`define NVC_FIXED_KEYS 9'h003
`define NVC_KEY_THREAD 9'h1FF

// ==========================================================================
// Routing and timing
// ==========================================================================
`define NVC_NMI_PINS 64
`define NVC_SRC_FIXED 2'h0
`define NVC_SRC_DMA 2'h1
`define NVC_SRC_ROUTED 2'h2
`define NVC_STACK_WORDS 4'h8

`endif

// ==== rtl/nvc_pkg.sv ====
/*
 * Types shared by the nested vector controller modules.
 * Assumes nvc_consts.svh is on the include path.
 */
`default_nettype none

`include "nvc_consts.svh"

package nvc_pkg;

	typedef logic [8:0] nvc_key_type;
	typedef logic [5:0] nvc_num_type;
	typedef logic [7:0] nvc_prio_type;

	typedef enum logic [2:0] {
		NVC_BOOT_SP,
		NVC_BOOT_PC,
		NVC_READY,
		NVC_STACK,
		NVC_FETCH,
		NVC_UNSTACK
	} nvc_state_type;

endpackage

`default_nettype wire

// ==== rtl/nvc_arbiter.sv ====
/*
 * Picks the requesting exception with the lowest key; on equal keys the
 * lower exception number wins.
 * Assumes keys are already masked to the implemented priority bits.
 */
`default_nettype none

`include "nvc_consts.svh"

module nvc_arbiter (
	input wire logic [`NVC_EXC_NUM-1:0] req_i,
	input wire nvc_pkg::nvc_key_type [`NVC_EXC_NUM-1:0] key_i,
	output logic found_o,
	output nvc_pkg::nvc_num_type num_o,
	output nvc_pkg::nvc_key_type key_o
);
	import nvc_pkg::*;

	// Scanning downward with <= lets the lower number take a tie.
	always_comb begin
		found_o = 1'b0;
		num_o = '0;
		key_o = `NVC_KEY_THREAD;
		for (int i = `NVC_EXC_NUM - 1; i >= 0; i--) begin
			if (req_i[i] && (!found_o || key_i[i] <= key_o)) begin
				found_o = 1'b1;
				num_o = 6'(i);
				key_o = key_i[i];
			end
		end
	end

endmodule

`default_nettype wire

// ==== rtl/nvc_top.sv ====
/*
 * Nested vector controller: pends system exceptions and 32 routed
 * peripheral requests, arbitrates them by priority, drives stacking,
 * vector fetch, tail-chaining and late arrival for the core.
 * Assumes the core answers each vector fetch with a one-cycle vec_ack_i,
 * pulses exc_return_i once per handler exit, and that all request sources
 * except the NMI pins run on clk_sys_i.
 */
`default_nettype none

`include "nvc_consts.svh"

module nvc_top (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [`NVC_NMI_PINS-1:0] nmi_pins_i,
	input wire logic [5:0] nmi_sel_i,
	input wire logic nmi_route_en_i,
	input wire logic [`NVC_IRQ_NUM-1:0] fixed_irq_i,
	input wire logic [15:0] dma_term0_i,
	input wire logic [15:0] dma_term1_i,
	input wire logic [`NVC_IRQ_NUM-1:0] routed_irq_i,
	input wire logic [2*`NVC_IRQ_NUM-1:0] src_sel_i,
	input wire logic [`NVC_IRQ_NUM-1:0] irq_en_i,
	input wire nvc_pkg::nvc_prio_type [`NVC_EXC_NUM-1:0] prio_i,
	input wire logic [3:0] prio_bits_i,
	input wire logic [2:0] prio_group_i,
	input wire logic mask_i,
	input wire logic [2:0] fault_en_i,
	input wire logic mem_fault_i,
	input wire logic bus_fault_i,
	input wire logic usage_fault_i,
	input wire logic supervisor_call_i,
	input wire logic debug_mon_i,
	input wire logic deferred_service_request_i,
	input wire logic system_tick_timer_i,
	input wire logic exc_return_i,
	input wire logic vec_ack_i,
	input wire logic [31:0] vec_data_i,
	output logic vec_req_o,
	output logic [`NVC_OFF_W-1:0] vec_off_o,
	output logic [31:0] main_stack_pointer_o,
	output logic [31:0] handler_addr_o,
	output logic handler_start_o,
	output logic vec_lsb_err_o,
	output logic stack_push_o,
	output logic stack_pop_o,
	output logic tail_chain_o,
	output logic late_arrival_o,
	output logic [5:0] exc_active_o,
	output logic thread_mode_o
);
	import nvc_pkg::*;

	// ======================================================================
	// Key functions
	// ======================================================================
	// Keys are unsigned, lower is more urgent: reset 0, NMI 1, hard fault 2,
	// programmable values start above them.
	function automatic nvc_prio_type prio_mask(input logic [3:0] bits);
		logic [3:0] b;
		b = bits;
		if (b < `NVC_PRIO_MIN_BITS)
			b = `NVC_PRIO_MIN_BITS;
		if (b > `NVC_PRIO_MAX_BITS)
			b = `NVC_PRIO_MAX_BITS;
		return 8'(8'hFF << (`NVC_PRIO_MAX_BITS - b));
	endfunction

	function automatic nvc_key_type key_of(input int num,
			input nvc_prio_type prio, input logic [3:0] bits,
			input logic [2:0] grp, input logic group_only);
		nvc_prio_type p;
		p = prio & prio_mask(bits);
		if (num <= int'(`NVC_EXC_HARD))
			return 9'(num - 1);
		if (group_only)
			p = 8'({1'b0, p} >> ({1'b0, grp} + 4'h1));
		return `NVC_FIXED_KEYS + {1'b0, p};
	endfunction

	// ======================================================================
	// Registers
	// ======================================================================
	nvc_state_type state_reg, state_next;
	logic [`NVC_EXC_NUM-1:0] pend_reg, pend_next;
	logic [`NVC_EXC_NUM-1:0] act_reg, act_next;
	nvc_num_type entry_reg, entry_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [2:0] nmi_sync_reg;
	logic nmi_lvl_reg;
	logic tail_reg, tail_next;
	logic [31:0] msp_reg;
	logic [31:0] haddr_reg;
	logic start_reg;
	logic lsb_err_reg;
	logic vreq_reg;
	logic [`NVC_OFF_W-1:0] voff_reg;
	logic push_reg, pop_reg, tail_o_reg, late_reg;
	logic [5:0] exc_act_reg;
	logic thread_reg;

	// ======================================================================
	// NMI pin selection and synchroniser
	// ======================================================================
	wire logic nmi_pin;
	wire logic nmi_stable;
	wire logic nmi_rise;

	assign nmi_pin = nmi_route_en_i & nmi_pins_i[nmi_sel_i];
	assign nmi_stable = nmi_sync_reg[1] == nmi_sync_reg[2];
	assign nmi_rise = nmi_stable & nmi_sync_reg[1] & ~nmi_lvl_reg;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			nmi_sync_reg <= 3'h0;
			nmi_lvl_reg <= 1'b0;
		end else begin
			nmi_sync_reg <= {nmi_sync_reg[1:0], nmi_pin};
			if (nmi_stable)
				nmi_lvl_reg <= nmi_sync_reg[1];
		end
	end

	// ======================================================================
	// Peripheral source routing
	// ======================================================================
	wire logic [`NVC_IRQ_NUM-1:0] dma_line;
	wire logic [`NVC_IRQ_NUM-1:0] irq_src;

	// Vectors 0..15 see the first DMA output bank, 16..31 the second.
	assign dma_line = {dma_term1_i, dma_term0_i};

	generate
		for (genvar v = 0; v < `NVC_IRQ_NUM; v++) begin : g_src
			wire logic [1:0] sel;
			assign sel = src_sel_i[2*v+1:2*v];
			assign irq_src[v] =
				sel == `NVC_SRC_FIXED ? fixed_irq_i[v] :
				sel == `NVC_SRC_DMA ? dma_line[v] :
				sel == `NVC_SRC_ROUTED ? routed_irq_i[v] :
				1'b0;
		end
	endgenerate

	// ======================================================================
	// Keys and arbitration
	// ======================================================================
	wire nvc_key_type [`NVC_EXC_NUM-1:0] full_key;
	wire nvc_key_type [`NVC_EXC_NUM-1:0] grp_key;

	generate
		for (genvar e = 0; e < `NVC_EXC_NUM; e++) begin : g_key
			assign full_key[e] = key_of(e, prio_i[e], prio_bits_i,
				prio_group_i, 1'b0);
			assign grp_key[e] = key_of(e, prio_i[e], prio_bits_i,
				prio_group_i, 1'b1);
		end
	endgenerate

	wire logic [`NVC_EXC_NUM-1:0] eligible;
	wire logic win_found;
	nvc_num_type win_num;
	wire logic lvl_found;
	nvc_num_type lvl_num;
	nvc_key_type lvl_key;
	wire logic rest_found;
	nvc_num_type rest_num;
	nvc_key_type rest_key;
	wire logic [`NVC_EXC_NUM-1:0] act_rest;
	wire nvc_key_type level_key;
	wire nvc_key_type rest_level;
	wire nvc_key_type win_grp;

	// The mask holds back every programmable exception; 2 and 3 still pass.
	assign eligible = pend_reg & ~({{(`NVC_EXC_NUM-4){mask_i}}, 4'h0});
	assign act_rest = act_reg & ~(`NVC_EXC_NUM'(1) << lvl_num);
	assign level_key = lvl_found ? lvl_key : `NVC_KEY_THREAD;
	assign rest_level = rest_found ? rest_key : `NVC_KEY_THREAD;
	assign win_grp = grp_key[win_num];

	nvc_arbiter u_win (
		.req_i(eligible),
		.key_i(full_key),
		.found_o(win_found),
		.num_o(win_num),
		.key_o()
	);

	nvc_arbiter u_level (
		.req_i(act_reg),
		.key_i(grp_key),
		.found_o(lvl_found),
		.num_o(lvl_num),
		.key_o(lvl_key)
	);

	nvc_arbiter u_rest (
		.req_i(act_rest),
		.key_i(grp_key),
		.found_o(rest_found),
		.num_o(rest_num),
		.key_o(rest_key)
	);

	// ======================================================================
	// Pending set and escalation
	// ======================================================================
	wire logic [2:0] fault_hit;
	wire logic [2:0] fault_blocked;
	wire logic escalate;
	logic [`NVC_EXC_NUM-1:0] pend_set;
	logic [`NVC_EXC_NUM-1:0] pend_clr;

	assign fault_hit = {usage_fault_i, bus_fault_i, mem_fault_i};

	generate
		for (genvar f = 0; f < 3; f++) begin : g_fault
			assign fault_blocked[f] = ~fault_en_i[f] | mask_i |
				(grp_key[4+f] >= level_key);
		end
	endgenerate

	assign escalate = |(fault_hit & fault_blocked);

	always_comb begin
		pend_set = '0;
		pend_set[`NVC_EXC_NMI] = nmi_rise;
		pend_set[`NVC_EXC_HARD] = escalate;
		pend_set[`NVC_EXC_MEM] = mem_fault_i & ~fault_blocked[0];
		pend_set[`NVC_EXC_BUS] = bus_fault_i & ~fault_blocked[1];
		pend_set[`NVC_EXC_USAGE] = usage_fault_i & ~fault_blocked[2];
		pend_set[`NVC_EXC_SVC] = supervisor_call_i;
		pend_set[`NVC_EXC_DEBUG] = debug_mon_i;
		pend_set[`NVC_EXC_DEFER] = deferred_service_request_i;
		pend_set[`NVC_EXC_TICK] = system_tick_timer_i;
		// A level request pends only while its vector is not active, so the
		// entry that activates it also clears its pending bit.
		pend_set[`NVC_EXC_NUM-1:`NVC_IRQ_BASE] = irq_src & irq_en_i &
			~act_next[`NVC_EXC_NUM-1:`NVC_IRQ_BASE];
	end

	// ======================================================================
	// Sequencer
	// ======================================================================
	wire logic win_preempts;
	wire logic win_tail;
	wire logic win_late;
	wire logic stack_done;
	wire logic fetch_state_next;
	wire logic [`NVC_OFF_W-1:0] entry_off;

	assign win_preempts = win_found & (win_grp < level_key);
	assign win_tail = win_found & (win_grp < rest_level);
	assign win_late = win_found & (win_grp < grp_key[entry_reg]);
	assign stack_done = cnt_reg == `NVC_STACK_WORDS - 4'h1;
	assign fetch_state_next = state_next == NVC_BOOT_SP ||
		state_next == NVC_BOOT_PC || state_next == NVC_FETCH;
	assign entry_off = {2'b00, entry_next, 2'b00};

	always_comb begin
		state_next = state_reg;
		entry_next = entry_reg;
		cnt_next = cnt_reg;
		tail_next = 1'b0;
		act_next = act_reg;
		pend_clr = '0;
		unique case (state_reg)
			NVC_BOOT_SP: begin
				if (vec_ack_i)
					state_next = NVC_BOOT_PC;
			end
			NVC_BOOT_PC: begin
				if (vec_ack_i)
					state_next = NVC_READY;
			end
			NVC_READY: begin
				if (exc_return_i && lvl_found) begin
					act_next[lvl_num] = 1'b0;
					if (win_tail) begin
						// Frame stays on the stack for the next handler.
						state_next = NVC_FETCH;
						entry_next = win_num;
						tail_next = 1'b1;
					end else begin
						state_next = NVC_UNSTACK;
						cnt_next = 4'h0;
					end
				end else if (win_preempts) begin
					state_next = NVC_STACK;
					entry_next = win_num;
					cnt_next = 4'h0;
				end
			end
			NVC_STACK: begin
				if (win_late)
					entry_next = win_num;
				cnt_next = cnt_reg + 4'h1;
				if (stack_done)
					state_next = NVC_FETCH;
			end
			NVC_FETCH: begin
				if (vec_ack_i) begin
					state_next = NVC_READY;
					act_next[entry_reg] = 1'b1;
					pend_clr[entry_reg] = 1'b1;
				end
			end
			NVC_UNSTACK: begin
				cnt_next = cnt_reg + 4'h1;
				if (stack_done)
					state_next = NVC_READY;
			end
		endcase
	end

	// A new event wins over the clear of its own pending bit.
	assign pend_next = ((pend_reg & ~pend_clr) | pend_set) &
		~`NVC_NEVER_PEND;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			state_reg <= NVC_BOOT_SP;
			pend_reg <= '0;
			act_reg <= '0;
			entry_reg <= '0;
			cnt_reg <= 4'h0;
			tail_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			pend_reg <= pend_next;
			act_reg <= act_next;
			entry_reg <= entry_next;
			cnt_reg <= cnt_next;
			tail_reg <= tail_next;
		end
	end

	// ======================================================================
	// Core-facing outputs
	// ======================================================================
	wire logic [`NVC_OFF_W-1:0] off_next;
	wire logic handler_take;

	assign off_next = state_next == NVC_BOOT_SP ? `NVC_OFF_STACK :
		state_next == NVC_BOOT_PC ? `NVC_OFF_RESET : entry_off;
	assign handler_take = vec_ack_i &&
		(state_reg == NVC_FETCH || state_reg == NVC_BOOT_PC);

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			vreq_reg <= 1'b0;
			voff_reg <= `NVC_OFF_STACK;
			msp_reg <= 32'h0000_0000;
			haddr_reg <= 32'h0000_0000;
			start_reg <= 1'b0;
			lsb_err_reg <= 1'b0;
			push_reg <= 1'b0;
			pop_reg <= 1'b0;
			tail_o_reg <= 1'b0;
			late_reg <= 1'b0;
			exc_act_reg <= 6'h00;
			thread_reg <= 1'b1;
		end else begin
			vreq_reg <= fetch_state_next;
			voff_reg <= off_next;
			if (vec_ack_i && state_reg == NVC_BOOT_SP)
				msp_reg <= vec_data_i;
			if (handler_take)
				haddr_reg <= vec_data_i;
			start_reg <= handler_take;
			if (handler_take)
				lsb_err_reg <= ~vec_data_i[0];
			push_reg <= state_next == NVC_STACK;
			pop_reg <= state_next == NVC_UNSTACK;
			tail_o_reg <= tail_next;
			late_reg <= state_reg == NVC_STACK && win_late;
			exc_act_reg <= state_next == NVC_FETCH ? entry_next :
				(state_next == NVC_UNSTACK && rest_found) ? rest_num :
				(|act_next ? exc_act_reg : 6'h00);
			thread_reg <= ~|act_next;
		end
	end

	assign vec_req_o = vreq_reg;
	assign vec_off_o = voff_reg;
	assign main_stack_pointer_o = msp_reg;
	assign handler_addr_o = haddr_reg;
	assign handler_start_o = start_reg;
	assign vec_lsb_err_o = lsb_err_reg;
	assign stack_push_o = push_reg;
	assign stack_pop_o = pop_reg;
	assign tail_chain_o = tail_o_reg;
	assign late_arrival_o = late_reg;
	assign exc_active_o = exc_act_reg;
	assign thread_mode_o = thread_reg;

endmodule

`default_nettype wire

// ==== testbench/nvc_core_model.sv ====
/* Core model that answers the controller's vector fetches.
   Assumes it shares clock and reset with the controller. */
`default_nettype none
module nvc_core_model (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic vec_req_i,
	input wire logic [9:0] vec_off_i,
	input wire logic [3:0] delay_i,
	input wire logic bad_lsb_i,
	output logic vec_ack_o,
	output logic [31:0] vec_data_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] wait_reg;
	// Stack pointer at offset zero, elsewhere a handler address that is odd unless bad_lsb_i is set.
	wire logic [31:0] word = (vec_off_i == 10'h000) ? 32'h2000_8000 :
		{22'h000004, vec_off_i[9:1], ~bad_lsb_i};
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			vec_ack_o <= 1'h0;
			wait_reg <= 4'h0;
			vec_data_o <= 32'h0;
		end else if (!vec_ack_o && vec_req_i && wait_reg >= delay_i) begin
			vec_ack_o <= 1'h1;
			vec_data_o <= word;
		end else begin
			vec_ack_o <= 1'h0;
			wait_reg <= (vec_req_i && !vec_ack_o) ? wait_reg + 4'h1 : 4'h0;
			// Outside a fetch the data lines toggle rather than hold.
			vec_data_o <= ~vec_data_o;
		end
	end
endmodule
`default_nettype wire

// ==== testbench/nvc_top_properties.sv ====
/* Checker watching the controller's ports.
   Assumes it is bound into nvc_top by the testbench. */
`default_nettype none
module nvc_top_properties (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic vec_ack_i,
	input wire logic [31:0] vec_data_i,
	input wire logic exc_return_i,
	input wire logic vec_req_o,
	input wire logic [9:0] vec_off_o,
	input wire logic [31:0] main_stack_pointer_o,
	input wire logic [31:0] handler_addr_o,
	input wire logic handler_start_o,
	input wire logic vec_lsb_err_o,
	input wire logic stack_push_o,
	input wire logic stack_pop_o,
	input wire logic tail_chain_o,
	input wire logic [5:0] exc_active_o,
	input wire logic thread_mode_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==================================================================
	// Properties
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	chk_push_eight: assert property (
		$rose(stack_push_o) |-> stack_push_o[*8] ##1 !stack_push_o)
		else $error("stacking length wrong");
	chk_pop_eight: assert property (
		$rose(stack_pop_o) |-> stack_pop_o[*8] ##1 !stack_pop_o)
		else $error("unstacking length wrong");
	chk_fetch_offset: assert property (
		vec_req_o && !thread_mode_o |-> vec_off_o == {exc_active_o, 2'h0})
		else $error("fetch offset wrong");
	chk_handler_load: assert property (
		vec_req_o && vec_ack_i && vec_off_o != 10'h000 |=>
		handler_start_o && handler_addr_o == $past(vec_data_i))
		else $error("handler address not loaded");
	chk_stack_load: assert property (
		vec_req_o && vec_ack_i && vec_off_o == 10'h000 |=>
		main_stack_pointer_o == $past(vec_data_i) && !handler_start_o)
		else $error("stack pointer not loaded");
	chk_lsb_flag: assert property (
		handler_start_o |-> vec_lsb_err_o == !handler_addr_o[0])
		else $error("lsb flag wrong");
	chk_no_reserved: assert property (
		!thread_mode_o |->
		!(exc_active_o inside {6'h0, 6'h1, [6'h7:6'hA], 6'hD}))
		else $error("reserved exception active");
	chk_tail_direct: assert property (
		tail_chain_o |->
		(!stack_pop_o && !stack_push_o) throughout (##[0:2] vec_req_o))
		else $error("tail chain not direct");
	chk_return_exit: assert property (
		exc_return_i && !thread_mode_o && !vec_req_o && !stack_push_o &&
		!stack_pop_o |-> ##[1:2] (stack_pop_o || tail_chain_o))
		else $error("return not handled");
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
/* Self-checking bench for the nested vector controller.
   Assumes the core model and checker files are compiled first. */
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin errors++; \
	$display("CHECK FAILED at %0t: got %0h exp %0h", $time, got, exp); end end
`define WAIT(c, n) begin int k; k = 0; \
	do begin @(negedge clk_sys_i); k++; end while ((c) !== 1'b1 && k < n); \
	`CHK((c), 1'b1) end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import nvc_pkg::*;
	logic clk_sys_i = 1'h0, rst_i = 1'h1, bad_lsb = 1'h0;
	logic [63:0] nmi_pins_i = '0, src_sel_i = '1;
	logic [5:0] nmi_sel_i = '0, exc_active_o;
	logic nmi_route_en_i = 1'h0, mask_i = 1'h0, exc_return_i = 1'h0;
	logic [31:0] fixed_irq_i = '0, routed_irq_i = '0, irq_en_i = '0;
	logic [15:0] dma_term0_i = '0, dma_term1_i = '0;
	nvc_prio_type [47:0] prio_i = {48{8'h80}};
	logic [3:0] prio_bits_i = 4'h8, delay = 4'h0;
	logic [2:0] prio_group_i = 3'h0, fault_en_i = 3'h7;
	logic [6:0] evt = '0;
	logic vec_ack_i, vec_req_o, handler_start_o, vec_lsb_err_o;
	logic stack_push_o, stack_pop_o, tail_chain_o, thread_mode_o;
	logic late_arrival_o;
	logic [31:0] vec_data_i, main_stack_pointer_o, handler_addr_o;
	logic [9:0] vec_off_o;
	int errors = 0, checks = 0;
	always #2 clk_sys_i = ~clk_sys_i;
	nvc_top nvc_top_inst (.clk_sys_i, .rst_i, .nmi_pins_i, .nmi_sel_i,
		.nmi_route_en_i, .fixed_irq_i, .dma_term0_i, .dma_term1_i,
		.routed_irq_i, .src_sel_i, .irq_en_i, .prio_i, .prio_bits_i,
		.prio_group_i, .mask_i, .fault_en_i, .mem_fault_i(evt[0]),
		.bus_fault_i(evt[1]), .usage_fault_i(evt[2]),
		.supervisor_call_i(evt[3]), .debug_mon_i(evt[4]),
		.deferred_service_request_i(evt[5]), .system_tick_timer_i(evt[6]),
		.exc_return_i, .vec_ack_i, .vec_data_i, .vec_req_o, .vec_off_o,
		.main_stack_pointer_o, .handler_addr_o, .handler_start_o,
		.vec_lsb_err_o, .stack_push_o, .stack_pop_o, .tail_chain_o,
		.late_arrival_o, .exc_active_o, .thread_mode_o);
	nvc_core_model nvc_core_model_inst (.clk_sys_i, .rst_i,
		.vec_req_i(vec_req_o), .vec_off_i(vec_off_o), .delay_i(delay),
		.bad_lsb_i(bad_lsb), .vec_ack_o(vec_ack_i), .vec_data_o(vec_data_i));
	// ==================================================================
	// Shared steps
	task automatic expect_entry(input logic [9:0] off);
		`WAIT(vec_req_o, 200)
		`CHK(vec_off_o, off)
		`WAIT(handler_start_o, 60)
		`CHK(handler_addr_o, 32'h0000_1001 + {22'h0, off})
	endtask
	task automatic leave();
		@(posedge clk_sys_i) exc_return_i <= 1'h1;
		@(posedge clk_sys_i) exc_return_i <= 1'h0;
	endtask
	task automatic idle();
		leave();
		`WAIT(thread_mode_o === 1'b1 && stack_pop_o === 1'b0, 40)
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// ==================================================================
	// Scenarios
	task automatic t_boot();
		`WAIT(handler_start_o, 40)
		`CHK(main_stack_pointer_o, 32'h2000_8000)
		`CHK(handler_addr_o, 32'h0000_1005)
		`CHK(thread_mode_o, 1'b1)
		$display("test boot done");
	endtask
	task automatic t_sources();
		int v[4] = '{2, 2, 20, 9};
		logic [1:0] s[4] = '{2'h0, 2'h1, 2'h1, 2'h2};
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys_i);
			delay <= 4'(i * 3);
			src_sel_i[2*v[i] +: 2] <= s[i];
			irq_en_i[v[i]] <= 1'h1;
			fixed_irq_i[v[i]] <= (s[i] == 2'h0);
			routed_irq_i[v[i]] <= (s[i] == 2'h2);
			if (v[i] < 16) dma_term0_i[v[i]] <= (s[i] == 2'h1);
			else dma_term1_i[v[i] - 16] <= (s[i] == 2'h1);
			expect_entry(10'h040 + 10'(4 * v[i]));
			@(posedge clk_sys_i);
			{fixed_irq_i, routed_irq_i} <= '0;
			{dma_term0_i, dma_term1_i} <= '0;
			idle();
		end
		$display("test sources done");
	endtask
	task automatic t_events();
		logic [9:0] off[9] = '{10'h010, 10'h014, 10'h018, 10'h02C, 10'h030,
			10'h038, 10'h03C, 10'h00C, 10'h00C};
		int e[9] = '{0, 1, 2, 3, 4, 5, 6, 0, 1};
		for (int i = 0; i < 9; i++) begin
			@(posedge clk_sys_i);
			fault_en_i <= (i == 7) ? 3'h6 : 3'h7;
			mask_i <= (i == 8);
			evt[e[i]] <= 1'h1;
			@(posedge clk_sys_i) evt <= '0;
			expect_entry(off[i]);
			idle();
		end
		@(posedge clk_sys_i) mask_i <= 1'h0;
		$display("test events done");
	endtask
	task automatic t_nmi();
		@(posedge clk_sys_i);
		nmi_sel_i <= 6'h28;
		nmi_route_en_i <= 1'h1;
		nmi_pins_i <= 64'h0000_0100_0000_0000;
		expect_entry(10'h008);
		@(posedge clk_sys_i) nmi_pins_i <= '0;
		idle();
		@(posedge clk_sys_i);
		nmi_route_en_i <= 1'h0;
		nmi_pins_i <= '1;
		repeat (30) @(negedge clk_sys_i);
		`CHK(thread_mode_o, 1'b1)
		@(posedge clk_sys_i) nmi_pins_i <= '0;
		$display("test nmi done");
	endtask
	task automatic tie(input logic [3:0] bits, input logic [9:0] a, b,
			input int ia);
		@(posedge clk_sys_i);
		prio_bits_i <= bits;
		prio_i[17] <= 8'h30;
		prio_i[19] <= 8'h20;
		src_sel_i[7:0] <= 8'h00;
		irq_en_i[3:0] <= 4'hF;
		fixed_irq_i[3:0] <= 4'hA;
		expect_entry(a);
		@(posedge clk_sys_i) fixed_irq_i[ia] <= 1'h0;
		leave();
		`WAIT(tail_chain_o, 10)
		expect_entry(b);
		@(posedge clk_sys_i) fixed_irq_i <= '0;
		idle();
		$display("test tie done");
	endtask
	task automatic t_group();
		@(posedge clk_sys_i);
		prio_group_i <= 3'h7;
		prio_i[22] <= 8'h10;
		src_sel_i[13:10] <= 4'h0;
		irq_en_i[6:5] <= 2'h3;
		fixed_irq_i <= 32'h0000_0020;
		expect_entry(10'h054);
		@(posedge clk_sys_i) fixed_irq_i <= 32'h0000_0040;
		repeat (20) @(negedge clk_sys_i);
		`CHK(exc_active_o, 6'h15)
		leave();
		expect_entry(10'h058);
		@(posedge clk_sys_i) fixed_irq_i <= '0;
		idle();
		@(posedge clk_sys_i);
		prio_group_i <= 3'h0;
		fixed_irq_i <= 32'h0000_0020;
		expect_entry(10'h054);
		@(posedge clk_sys_i) fixed_irq_i <= 32'h0000_0040;
		expect_entry(10'h058);
		@(posedge clk_sys_i) fixed_irq_i <= '0;
		leave();
		`WAIT(stack_pop_o, 6)
		`WAIT(!stack_pop_o, 12)
		`CHK(exc_active_o, 6'h15)
		idle();
		$display("test group done");
	endtask
	task automatic t_late();
		@(posedge clk_sys_i) fixed_irq_i <= 32'h0000_0020;
		repeat (3) @(posedge clk_sys_i);
		fixed_irq_i <= 32'h0000_0060;
		`WAIT(late_arrival_o, 12)
		expect_entry(10'h058);
		@(posedge clk_sys_i) fixed_irq_i <= 32'h0000_0020;
		leave();
		expect_entry(10'h054);
		@(posedge clk_sys_i) fixed_irq_i <= '0;
		idle();
		$display("test late done");
	endtask
	task automatic t_lsb();
		@(posedge clk_sys_i) bad_lsb <= 1'h1;
		evt[3] <= 1'h1;
		@(posedge clk_sys_i) evt <= '0;
		`WAIT(handler_start_o, 60)
		`CHK(vec_lsb_err_o, 1'b1)
		@(posedge clk_sys_i) bad_lsb <= 1'h0;
		idle();
		$display("test lsb done");
	endtask
	initial begin
		repeat (16) @(posedge clk_sys_i);
		rst_i <= 1'h0;
		t_boot();
		t_sources();
		t_events();
		t_nmi();
		tie(4'h3, 10'h044, 10'h04C, 1);
		tie(4'h8, 10'h04C, 10'h044, 3);
		t_group();
		t_late();
		t_lsb();
		conclude();
	end
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		errors++;
		conclude();
	end
endmodule
bind nvc_top nvc_top_properties nvc_top_properties_inst (.clk_sys_i, .rst_i,
	.vec_ack_i, .vec_data_i, .exc_return_i, .vec_req_o, .vec_off_o,
	.main_stack_pointer_o, .handler_addr_o, .handler_start_o,
	.vec_lsb_err_o, .stack_push_o, .stack_pop_o, .tail_chain_o,
	.exc_active_o, .thread_mode_o);
`default_nettype wire
